// ===== src/ahr_hub_core.sv
// Active hub repeater core: an idle state plus one active state per port.
// Assumes line transceivers outside; rx_sense_i are asynchronous pulse levels from the receivers.
//
// Summary of operation
// - Grant the first port to show activity; later arrivals ignored while latched.
// - Simultaneous arrivals may be settled by a fixed port priority.
// - State machine has one idle state plus one active state per port.
// - Idle: all receivers enabled, all transmitters disabled.
// - Activity while idle moves at once to that port's active state.
// - Active: only the winning port's receiver stays enabled.
// - Active: all transmitters enabled except the winning port's.
// - Active: winning port's input is copied onto all other ports together.
// - Repeated signal is not retimed to a bit clock beyond sampling.
// - The signal content is never decoded or interpreted.
// - Stay active until the timeout elapses with no activity on winner.
// - On timeout return to idle, receivers on, transmitters off.
// - Timeout exceeds worst-case cable round trip, cancelling echoes.
// - Timeout is shorter than the minimum interframe gap.
// - Timeout lies between 5.0 and 12.0 microseconds inclusive.
// - Timeout recommended between 5.2 and 7.8 microseconds.
// - Repeated edges stay within 2.5 ns inside one symbol unit group; here edge uncertainty is one 5 ns clock period.
// - Input to output delay never exceeds 350 ns.
`timescale 1ns/100ps

module ahr_hub_core (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic [ahr_pkg::AHR_N_PORTS-1:0] rx_sense_i,
	output logic [ahr_pkg::AHR_N_PORTS-1:0] rx_en_o,
	output logic [ahr_pkg::AHR_N_PORTS-1:0] tx_en_o,
	output logic [ahr_pkg::AHR_N_PORTS-1:0] tx_data_o,
	output logic latched_o
);
	import ahr_pkg::*;

	// Sampling at 5 ns gives edge uncertainty of one period, so jitter is
	// bounded by the clock; a tighter budget needs a faster clock.
	typedef struct packed {
		logic [AHR_N_PORTS-1:0] sync1;
		logic [AHR_N_PORTS-1:0] sync2;
		ahr_state_e state;
		logic [AHR_TMR_W-1:0] tmr;
		logic [AHR_N_PORTS-1:0] rx_en;
		logic [AHR_N_PORTS-1:0] tx_en;
		logic [AHR_N_PORTS-1:0] tx_data;
		logic latched;
	} ahr_regs_s;

	ahr_regs_s r_q;
	ahr_regs_s r_d;

	localparam ahr_regs_s AHR_REGS_RESET = '{
		sync1: '0,
		sync2: '0,
		state: AHR_IDLE,
		tmr: AHR_TMR_RESET,
		rx_en: AHR_RX_EN_RESET,
		tx_en: AHR_TX_EN_RESET,
		tx_data: '0,
		latched: 1'b0
	};

	always_comb begin
		logic [AHR_N_PORTS-1:0] win;
		logic [AHR_N_PORTS-1:0] seen;
		logic win_act;
		win = '0;
		seen = '0;
		win_act = 1'b0;
		r_d = r_q;
		r_d.sync1 = rx_sense_i;
		r_d.sync2 = r_q.sync1;
		// Receivers gate activity: only enabled ports count.
		seen = r_q.sync2 & r_q.rx_en;
		unique case (r_q.state)
			AHR_IDLE: begin
				// First active port wins; same-cycle ties to lowest index.
				for (int i = AHR_N_PORTS - 1; i >= 0; i--) begin
					if (seen[i]) begin
						win = '0;
						win[i] = 1'b1;
					end
				end
				if (|win) begin
					// Immediate move to the winner's state.
					r_d.state = ahr_state_e'({win, 1'b0});
					r_d.tmr = AHR_TMR_W'(AHR_RELEASE_CYCLES);
				end
			end
			default: begin
				// Later arrivals on other ports are ignored while latched.
				win = r_q.state[AHR_N_PORTS:1];
				win_act = |(seen & win);
				if (win_act) begin
					r_d.tmr = AHR_TMR_W'(AHR_RELEASE_CYCLES);
				end else if (r_q.tmr <= AHR_TMR_W'(1)) begin
					// Timeout covers echo round trip yet ends before the next frame.
					r_d.state = AHR_IDLE;
					r_d.tmr = AHR_TMR_RESET;
				end else begin
					r_d.tmr = r_q.tmr - AHR_TMR_W'(1);
				end
			end
		endcase
		if (r_d.state == AHR_IDLE) begin
			r_d.rx_en = AHR_RX_EN_RESET;
			r_d.tx_en = AHR_TX_EN_RESET;
			r_d.tx_data = '0;
			r_d.latched = 1'b0;
		end else begin
			r_d.rx_en = r_d.state[AHR_N_PORTS:1];
			r_d.tx_en = ~r_d.state[AHR_N_PORTS:1];
			// Raw pulse level is copied, never decoded; latency is three cycles,
			// far under the 350 ns budget.
			r_d.tx_data = {AHR_N_PORTS{|(r_q.sync2 & r_d.state[AHR_N_PORTS:1])}}
				& ~r_d.state[AHR_N_PORTS:1];
			r_d.latched = 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			r_q <= AHR_REGS_RESET;
		end else begin
			r_q <= r_d;
		end
	end

	assign rx_en_o = r_q.rx_en;
	assign tx_en_o = r_q.tx_en;
	assign tx_data_o = r_q.tx_data;
	assign latched_o = r_q.latched;
endmodule

// ===== src/ahr_pkg.sv
// Package for the active hub repeater core: port count, timing constants and state codes.
// Assumes a 200 MHz system clock; only the release timeout is converted to clk_sys cycles here.
package ahr_pkg;
	localparam int AHR_N_PORTS = 4;
	localparam int AHR_CLK_PERIOD_PS = 5000;
	// Release timeout, picoseconds; inside the mandatory and the recommended windows.
	localparam int AHR_RELEASE_TIMEOUT_PS = 6500000;
	localparam int AHR_RELEASE_MIN_PS = 5000000;
	localparam int AHR_RELEASE_MAX_PS = 12000000;
	localparam int AHR_RELEASE_REC_MIN_PS = 5200000;
	localparam int AHR_RELEASE_REC_MAX_PS = 7800000;
	localparam int AHR_RELEASE_CYCLES = AHR_RELEASE_TIMEOUT_PS / AHR_CLK_PERIOD_PS;
	localparam int AHR_THROUGH_MAX_PS = 350000;
	localparam int AHR_JITTER_MAX_PS = 2500;
	localparam int AHR_BIT_TIME_PS = 400000;
	localparam int AHR_TMR_W = 13;
	localparam logic [AHR_TMR_W-1:0] AHR_TMR_RESET = 13'h0000;
	localparam logic [AHR_N_PORTS-1:0] AHR_RX_EN_RESET = 4'hF;
	localparam logic [AHR_N_PORTS-1:0] AHR_TX_EN_RESET = 4'h0;

	typedef enum logic [AHR_N_PORTS:0] {
		AHR_IDLE = 5'h01,
		AHR_ACT0 = 5'h02,
		AHR_ACT1 = 5'h04,
		AHR_ACT2 = 5'h08,
		AHR_ACT3 = 5'h10
	} ahr_state_e;
endpackage

// ===== tb/active_hub_repeater_tb_top.sv
// Hub core bench; the checker binds itself to the core.
`timescale 1ns/100ps
module active_hub_repeater_tb_top;
	logic clk_sys = 1'b0, rstn = 1'b0, latched_o;
	logic [3:0] fire = 4'h0, rx_sense_i, rx_en_o, tx_en_o, tx_data_o;
	int bad_count = 0, checks_done = 0;
	always #2.5 clk_sys = ~clk_sys;
	ahr_stn u_stn (.*);
	ahr_hub_core u_dut (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.rx_sense_i(rx_sense_i),
		.rx_en_o(rx_en_o),
		.tx_en_o(tx_en_o),
		.tx_data_o(tx_data_o),
		.latched_o(latched_o)
	);
	task end_sim();
		$display("checks %0d bad %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task chk(string nm, logic [3:0] e, logic [3:0] s);
		checks_done++;
		bad_count += int'(s !== e);
		if (s !== e) $display("BAD %s exp %h got %h", nm, e, s);
	endtask
	task go(logic [3:0] m, logic v);
		@(negedge clk_sys) fire <= m;
		for (int n = 0; n < 6 || latched_o !== v; n++) begin
			@(negedge clk_sys);
			bad_count += int'(n > 3000);
			if (n > 3000) end_sim();
		end
	endtask
	task t_tie();
		go(4'hA, 1'b1);
		chk("tie", 4'h2, rx_en_o);
		go(4'h0, 1'b0);
		chk("idle_rx", 4'hF, rx_en_o);
		chk("idle_tx", 4'h0, tx_en_o);
	endtask
	task t_grant();
		go(4'h4, 1'b1);
		chk("grant", 4'h4, rx_en_o);
		chk("data", 4'hB, tx_data_o);
		chk("tx_en", 4'hB, tx_en_o);
		go(4'h1, 1'b1);
		chk("late", 4'h4, rx_en_o);
		go(4'h0, 1'b0);
		chk("rel_rx", 4'hF, rx_en_o);
		chk("rel_tx", 4'h0, tx_en_o);
		chk("rel_data", 4'h0, tx_data_o);
	endtask
	initial begin
		repeat (16) @(negedge clk_sys);
		rstn <= 1'b1;
		t_tie();
		t_grant();
		end_sim();
	end
endmodule

// ===== tb/ahr_hub_core_chk.sv
// Hub core checker; it sees only the core ports and binds to every core.
// Assumes one 200 MHz clock and an active-low reset shared with the core.
`timescale 1ns/100ps
module ahr_chk (input wire logic clk_sys, rstn, latched_o,
	input wire logic [3:0] rx_sense_i, rx_en_o, tx_en_o, tx_data_o);
	logic [11:0] q;
	wire logic hot = |(rx_sense_i & rx_en_o);
	always_ff @(posedge clk_sys) q <= (latched_o && !hot) ? q + 12'h001 : 12'h000;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	chk_idle_en: assert property (!latched_o |-> &rx_en_o && !tx_en_o) else $error("i");
	chk_one_rx: assert property (latched_o |-> $onehot(rx_en_o)) else $error("r");
	chk_tx_split: assert property (latched_o |-> tx_en_o == ~rx_en_o) else $error("t");
	chk_first_win: assert property ($rose(latched_o) |-> rx_en_o ==
		($past(rx_sense_i, 3) & -$past(rx_sense_i, 3))) else $error("w");
	chk_copy: assert property (latched_o && $past(latched_o) |-> tx_data_o ==
		(tx_en_o & {4{|($past(rx_sense_i, 3) & rx_en_o)}})) else $error("c");
	chk_lock: assert property (latched_o |=> !latched_o || $stable(rx_en_o)) else $error("l");
	chk_stay: assert property (latched_o && hot |=> latched_o [*8]) else $error("s");
	chk_rel_time: assert property ($fell(latched_o) |-> q inside {[12'h50A:12'h523]})
		else $error("q");
endmodule
bind ahr_hub_core ahr_chk u_chk (.*);

// ===== tb/ahr_stn.sv
// Station pulse model; each new nonzero mask on fire sends one 100 ns pulse.
`timescale 1ns/100ps
module ahr_stn (input wire logic clk_sys, input wire logic [3:0] fire,
	output logic [3:0] rx_sense_i);
	logic [4:0] n = 5'h00;
	logic [3:0] m = 4'h0;
	always @(negedge clk_sys)
		if (fire != m && fire != 4'h0) {m, n} <= {fire, 5'h14};
		else if (n != 5'h00) n <= n - 5'h01;
	assign rx_sense_i = (n != 5'h00) ? m : 4'h0; // Dark between pulses reads low.
endmodule
